// file: core/ussu_params.svh
// Constants for the universal serial shift unit
`ifndef USSU_PARAMS_SVH
`define USSU_PARAMS_SVH
`define USSU_DATA_W 8
`define USSU_CNT_W 4
`define USSU_CNT_MAX 4'hF
`define USSU_DATA_RST 8'h00
`define USSU_CNT_RST 4'h0
`define USSU_CLK_SYS_NS 100
`define USSU_STRETCH_NS 100
`define USSU_STRETCH_CYC ((`USSU_STRETCH_NS + `USSU_CLK_SYS_NS - 1) / `USSU_CLK_SYS_NS)
`define USSU_BUF_DEPTH 2
`define USSU_CS_SW 2'h0
`define USSU_CS_TIMER 2'h1
`define USSU_CS_EXT 2'h2
`define USSU_WM_NONE 2'h0
`define USSU_WM_THREE 2'h1
`define USSU_WM_TWO 2'h2
`endif

// file: core/ussu_pkg.sv
// Types for the universal serial shift unit
package ussu_pkg;
  // Control settings written by software
  typedef struct packed {
    logic [1:0] wire_mode;
    logic external_clock_select;
    logic clock_polarity_select;
    logic software_clock_strobe;
    logic clock_toggle_strobe;
  } ussu_ctrl_type;
  // Phase of the external clock relative to sampling
  typedef enum logic [0:0] {USSU_PH_SAMPLE, USSU_PH_SHIFT} ussu_phase_type;
endpackage

// file: core/ussu_buf.sv
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/100ps
`include "ussu_params.svh"
module ussu_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`USSU_DATA_W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [`USSU_DATA_W-1:0] out_data
);
  logic [`USSU_DATA_W-1:0] mem_reg [0:`USSU_BUF_DEPTH-1]; // Storage
  logic [`USSU_DATA_W-1:0] mem_next [0:`USSU_BUF_DEPTH-1];
  logic wr_reg, wr_next, rd_reg, rd_next; // One-bit pointers, depth two
  logic [1:0] cnt_reg, cnt_next; // Fill level
  logic push, pop;
  // Handshakes and next state
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = ~wr_reg;
    end
    if (pop) begin
      rd_next = ~rd_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_reg[0] <= `USSU_DATA_RST;
      mem_reg[1] <= `USSU_DATA_RST;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  // Honest full and empty
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_reg];
endmodule

// file: core/ussu_top.sv
// Universal serial shift unit: shift register, edge counter, clock select
// Notes on behaviour
// [R1] Eight-bit shift register, directly read and written
// [R2] Top bit routed to pin chosen by wire mode
// [R3] Latch delays output to opposite clock edge
// [R4] Input always sampled from serial input pin
// [R5] Four-bit counter readable, writable, overflow flag
// [R6] Shifter and counter share one clock source except in mixed mode
// [R7] External clock counts both edges
// [R8] Clock from pin, timer match, or strobe
// [R9] Three-wire mode like SPI modes 0/1
// [R10] Eight clock pulses exchange both registers
// [R11] Sixteen edges overflow, flag transfer complete
// [R12] Polarity select swaps sample and shift edges
// [R13] Toggle strobe toggles serial clock pin
// [R14] Far side loads data before first edge
// [R15] Far side zeroes counter before each byte
// [R16] Overflow flag can wake idle processor
// [R17] Master rate up to quarter system clock
// [R18] Status write clears flag and loads count
// [R19] Pin shifts, strobe counts in mixed mode
// [R20] Two-wire start interrupt, hold clock low
// [R21] Data write beats coincident shift
// [R22] Latch transparent first half external, always internal
// [R23] Counter wraps fifteen to zero, sets flag
// [R24] Serial clock pin synchronised before edge detect
`timescale 1ns/100ps
`include "ussu_params.svh"
module ussu_top
  import ussu_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Control settings
  input wire ussu_ctrl_type CTRL,
  input wire logic CTRL_WRITE,
  input wire logic TIMER_MATCH,
  // Data register access
  input wire logic DATA_WRITE,
  input wire logic [7:0] DATA_WDATA,
  output logic [7:0] DATA_RDATA,
  // Status access
  input wire logic STATUS_WRITE,
  input wire logic STATUS_WFLAG,
  input wire logic STATUS_WSTART,
  input wire logic [3:0] STATUS_WCOUNT,
  output logic [3:0] COUNT,
  output logic OVERFLOW_FLAG,
  output logic START_FLAG,
  output logic WAKE,
  // Received byte stream
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [7:0] RX_DATA,
  // Serial pins
  input wire logic SERIAL_IN_PIN,
  input wire logic SDA_IN,
  input wire logic SCK_IN,
  output logic SERIAL_OUT_PIN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic SCK_OUT,
  output logic SCK_OE
);
  // Synchronisers: first stage feeds only the second
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic sin_s1_reg, sin_s2_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  // Core state
  logic [7:0] shift_data_reg, shift_data_next;
  logic [3:0] cnt_reg, cnt_next;
  logic count_overflow_flag_reg, count_overflow_flag_next;
  logic start_flag_reg, start_flag_next;
  logic latch_reg, latch_next; // Output latch
  logic sck_drv_reg, sck_drv_next; // Driven clock level
  logic hold_reg, hold_next; // Two-wire clock stretch
  logic sdi_reg, sdi_next; // Sampled input bit
  ussu_phase_type phase_reg, phase_next;
  logic byte_done_reg, byte_done_next; // Push request to buffer
  logic out_reg, sda_out_reg, sda_oe_reg, wake_reg;
  logic sck_out_reg; // Clock pin level, low while stretched
  logic buf_in_ready, buf_out_valid;
  logic [7:0] buf_out_data;
  logic rx_valid_reg, rx_ready_i;
  logic [7:0] rx_data_reg;
  // Derived strobes
  logic ext_sel, sck_rise, sck_fall, sample_edge, shift_edge, ext_edge;
  logic sw_clk, shift_en, count_en, wrap, start_det, latch_open;
  logic [4:0] cnt_sum;
  // Sampling of pins
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      sin_s1_reg <= 1'b0;
      sin_s2_reg <= 1'b0;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      sck_s1_reg <= SCK_IN; // R24
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sin_s1_reg <= SERIAL_IN_PIN; // R4
      sin_s2_reg <= sin_s1_reg;
      sda_s1_reg <= SDA_IN;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end
  // Clock source selection and edge classification
  always_comb begin
    ext_sel = CTRL.external_clock_select;
    sck_rise = sck_s2_reg && !sck_s3_reg; // R24
    sck_fall = !sck_s2_reg && sck_s3_reg;
    ext_edge = sck_rise || sck_fall;
    // Polarity swaps which edge samples and which shifts
    sample_edge = CTRL.clock_polarity_select ? sck_fall : sck_rise; // R12
    shift_edge = CTRL.clock_polarity_select ? sck_rise : sck_fall; // R12
    sw_clk = CTRL_WRITE && CTRL.software_clock_strobe;
    // Internal sources shift once per event; external shifts on its shift edge
    if (ext_sel) begin
      shift_en = shift_edge; // R8 R9
      // Strobe counting with external shift clock
      count_en = CTRL.software_clock_strobe ? (CTRL_WRITE && CTRL.clock_toggle_strobe) : ext_edge; // R7 R19
    end else begin
      shift_en = CTRL.software_clock_strobe ? sw_clk : TIMER_MATCH; // R8 R17
      count_en = shift_en; // R6
    end
    cnt_sum = {1'b0, cnt_reg} + 5'h01;
    wrap = count_en && (cnt_reg == `USSU_CNT_MAX); // R11 R23
    // Start: data falls while clock high, two-wire only
    start_det = (CTRL.wire_mode == `USSU_WM_TWO) && sck_s2_reg && !sda_s2_reg && sda_s3_reg; // R20
    // Latch open in first half of external cycle, always for internal
    latch_open = !ext_sel || (phase_reg == USSU_PH_SAMPLE); // R22
  end
  // Next values for shifter, counter, flags
  always_comb begin
    shift_data_next = shift_data_reg;
    cnt_next = cnt_reg;
    count_overflow_flag_next = count_overflow_flag_reg;
    start_flag_next = start_flag_reg;
    latch_next = latch_reg;
    sck_drv_next = sck_drv_reg;
    hold_next = hold_reg;
    sdi_next = sdi_reg;
    phase_next = phase_reg;
    byte_done_next = byte_done_reg && !buf_in_ready;
    // External sample edge captures input; internal sources sample at shift time
    if (ext_sel && sample_edge) begin
      sdi_next = sin_s2_reg; // R4
      phase_next = USSU_PH_SHIFT;
    end
    if (ext_sel && shift_edge) begin
      phase_next = USSU_PH_SAMPLE;
    end
    // Software write wins over a coincident shift
    if (DATA_WRITE) begin
      shift_data_next = DATA_WDATA; // R1 R21
    end else if (shift_en) begin
      shift_data_next = {shift_data_reg[6:0], ext_sel ? sdi_reg : sin_s2_reg}; // R1 R10
    end
    if (count_en) begin
      cnt_next = cnt_sum[3:0]; // R5 R23
    end
    // Status write: flag clear and count load, set wins over clear
    if (STATUS_WRITE) begin
      cnt_next = STATUS_WCOUNT; // R5 R18
      if (STATUS_WFLAG) begin
        count_overflow_flag_next = 1'b0; // R18
      end
      if (STATUS_WSTART) begin
        start_flag_next = 1'b0;
        hold_next = 1'b0;
      end
    end
    if (wrap) begin
      count_overflow_flag_next = 1'b1; // R11 R23
      byte_done_next = 1'b1;
      if (CTRL.wire_mode == `USSU_WM_TWO) begin
        hold_next = 1'b1; // R20
      end
    end
    if (start_det) begin
      start_flag_next = 1'b1; // R20
      hold_next = 1'b1;
    end
    // Release of overflow stretch when flag cleared
    if (STATUS_WRITE && STATUS_WFLAG && !wrap && !start_flag_reg && !start_det) begin
      hold_next = 1'b0;
    end
    if (latch_open) begin
      latch_next = shift_data_next[7]; // R3 R22
    end
    if (CTRL_WRITE && CTRL.clock_toggle_strobe) begin
      sck_drv_next = ~sck_drv_reg; // R13 R17
    end
  end
  // Register the core state
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      shift_data_reg <= `USSU_DATA_RST;
      cnt_reg <= `USSU_CNT_RST;
      count_overflow_flag_reg <= 1'b0;
      start_flag_reg <= 1'b0;
      latch_reg <= 1'b0;
      sck_drv_reg <= 1'b0;
      hold_reg <= 1'b0;
      sdi_reg <= 1'b0;
      phase_reg <= USSU_PH_SAMPLE;
      byte_done_reg <= 1'b0;
    end else begin
      shift_data_reg <= shift_data_next;
      cnt_reg <= cnt_next;
      count_overflow_flag_reg <= count_overflow_flag_next;
      start_flag_reg <= start_flag_next;
      latch_reg <= latch_next;
      sck_drv_reg <= sck_drv_next;
      hold_reg <= hold_next;
      sdi_reg <= sdi_next;
      phase_reg <= phase_next;
      byte_done_reg <= byte_done_next;
    end
  end
  // Output pin routing by wire mode; two-wire pins are open drain
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      out_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wake_reg <= 1'b0;
      sck_out_reg <= 1'b0;
    end else begin
      out_reg <= (CTRL.wire_mode == `USSU_WM_THREE) ? latch_next : 1'b0; // R2 R9
      sda_out_reg <= 1'b0;
      sda_oe_reg <= (CTRL.wire_mode == `USSU_WM_TWO) && !latch_next; // R2
      wake_reg <= count_overflow_flag_next || start_flag_next; // R16
      // Registered from next values so the pin moves with the toggle
      sck_out_reg <= hold_next ? 1'b0 : sck_drv_next; // R13 R20
    end
  end
  // Received bytes queue so a reader three bytes behind loses nothing
  ussu_buf u_buf (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .in_valid(byte_done_reg),
    .in_ready(buf_in_ready),
    .in_data(shift_data_reg),
    .out_valid(buf_out_valid),
    .out_ready(rx_ready_i),
    .out_data(buf_out_data)
  );
  // Registered output stage for the byte stream
  assign rx_ready_i = !rx_valid_reg || RX_READY;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= `USSU_DATA_RST;
    end else if (rx_ready_i) begin
      rx_valid_reg <= buf_out_valid;
      rx_data_reg <= buf_out_data;
    end
  end
  // Port drives, all from flip-flops
  assign DATA_RDATA = shift_data_reg;
  assign COUNT = cnt_reg;
  assign OVERFLOW_FLAG = count_overflow_flag_reg;
  assign START_FLAG = start_flag_reg;
  assign WAKE = wake_reg;
  assign RX_VALID = rx_valid_reg;
  assign RX_DATA = rx_data_reg;
  assign SERIAL_OUT_PIN = out_reg;
  assign SDA_OUT = sda_out_reg;
  assign SDA_OE = sda_oe_reg;
  assign SCK_OUT = sck_out_reg;
  assign SCK_OE = hold_reg;
  // A counting event at fifteen wraps the counter and brings overflow
  property p_wrap_sets_flag;
    @(posedge CLK_SYS) disable iff (!RESETN) wrap |=> count_overflow_flag_reg;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("overflow flag not set on wrap"); // R11
  property p_wrap_zero;
    @(posedge CLK_SYS) disable iff (!RESETN) (wrap && !STATUS_WRITE) |=> (cnt_reg == 4'h0);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("counter did not wrap to zero"); // R23
  property p_clear;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (STATUS_WRITE && STATUS_WFLAG && STATUS_WCOUNT == 4'h0 && !wrap) |=> (!count_overflow_flag_reg && cnt_reg == 4'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("status write did not clear"); // R18
  property p_write_wins;
    @(posedge CLK_SYS) disable iff (!RESETN) DATA_WRITE |=> (shift_data_reg == $past(DATA_WDATA));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("data write lost"); // R21
  property p_shift;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (shift_en && !DATA_WRITE) |=> (shift_data_reg[7:1] == $past(shift_data_reg[6:0]));
  endproperty
  a_shift: assert property (p_shift) else $error("shift did not move data left"); // R1
  property p_ext_count;
    @(posedge CLK_SYS) disable iff (!RESETN)
      (ext_sel && !CTRL.software_clock_strobe && ext_edge && !STATUS_WRITE) |=> (cnt_reg == $past(cnt_reg) + 4'h1);
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("edge not counted"); // R7
  property p_toggle;
    @(posedge CLK_SYS) disable iff (!RESETN) (CTRL_WRITE && CTRL.clock_toggle_strobe) |=> (sck_drv_reg != $past(sck_drv_reg));
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock pin did not toggle"); // R13
  property p_latch_hold;
    @(posedge CLK_SYS) disable iff (!RESETN) !latch_open |=> $stable(latch_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed"); // R22
  property p_start_hold;
    @(posedge CLK_SYS) disable iff (!RESETN) start_det |=> (start_flag_reg && SCK_OE && !SCK_OUT);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not flagged or clock not held"); // R20
  property p_out_route;
    @(posedge CLK_SYS) disable iff (!RESETN) (CTRL.wire_mode == `USSU_WM_THREE) |=> (SERIAL_OUT_PIN == latch_reg);
  endproperty
  a_out_route: assert property (p_out_route) else $error("output pin not from latch"); // R2
endmodule

// file: verif/ussu_spi_master.sv
// Behavioural SPI-style master standing on the far side of the serial pins
`timescale 1ns/100ps
module ussu_spi_master (
  // Lines toward the unit
  output logic sck,
  output logic mosi,
  output logic sda,
  input wire logic miso
);
  // Half of the 800 ns link clock period
  localparam int HALF_NS = 400;

  // Clock stands still low outside frames
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sda = 1'b1;
  end

  // Two-wire start: data falls while the clock stands high, then clock low
  task automatic start_cond();
    sck = 1'b1;
    #HALF_NS;
    sda = 1'b0;
    #HALF_NS;
    sck = 1'b0;
    #HALF_NS;
    sda = 1'b1;
  endtask

  // One byte MSB first; mode 1 changes data on rising and samples on falling
  task automatic xfer(input logic [7:0] tx, input logic mode, output logic [7:0] rx);
    rx = 8'h00;
    mosi = tx[7];
    #HALF_NS;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b1;
      if (mode) mosi = tx[i];
      else rx[i] = miso;
      #HALF_NS;
      sck = 1'b0;
      if (mode) rx[i] = miso;
      else if (i > 0) mosi = tx[i-1];
      #HALF_NS;
    end
    // Released line must not keep showing the last bit
    mosi = ~mosi;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the universal serial shift unit
`timescale 1ns/100ps
`include "ussu_params.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  import ussu_pkg::*;
  // Clock, reset and control
  logic clk, resetn, ctrl_wr, tmr, dwr, swr, rx_ready;
  ussu_ctrl_type ctrl;
  logic [7:0] wdata, rdata, rx_data;
  logic [3:0] wcnt, cnt;
  // Observed outputs and link lines
  logic ovf, wake, rx_valid, so, sck_out, sck, si;
  logic wstart, sda, sflag, sda_out, sda_oe, sck_oe;
  int n_mismatch, compares;

  ussu_top dut_u (.CLK_SYS(clk), .RESETN(resetn), .CTRL(ctrl), .CTRL_WRITE(ctrl_wr), .TIMER_MATCH(tmr),
    .DATA_WRITE(dwr), .DATA_WDATA(wdata), .DATA_RDATA(rdata), .STATUS_WRITE(swr), .STATUS_WFLAG(1'b1),
    .STATUS_WSTART(wstart), .STATUS_WCOUNT(wcnt), .COUNT(cnt), .OVERFLOW_FLAG(ovf), .START_FLAG(sflag),
    .WAKE(wake), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data), .SERIAL_IN_PIN(si),
    .SDA_IN(sda), .SCK_IN(sck), .SERIAL_OUT_PIN(so), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe));

  // Far-side master owns the link clock and the data line into the unit
  ussu_spi_master spi_u (.sck(sck), .mosi(si), .sda(sda), .miso(so));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Report counts and verdict, then stop
  task automatic tally_and_finish();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Control level only; strobes need a separate write pulse
  task automatic cfg(input ussu_ctrl_type c);
    @(posedge clk);
    ctrl <= c;
  endtask

  // Write strobes (tm=0) or timer matches (tm=1), one every two cycles
  task automatic pulse(input int n, input logic tm);
    repeat (n) begin
      @(posedge clk);
      if (tm) tmr <= 1'b1;
      else ctrl_wr <= 1'b1;
      @(posedge clk);
      tmr <= 1'b0;
      ctrl_wr <= 1'b0;
    end
    @(negedge clk);
  endtask

  // Status write: clear flag and load count
  task automatic stw(input logic [3:0] c, input logic st = 1'b0);
    @(posedge clk);
    swr <= 1'b1;
    wstart <= st;
    wcnt <= c;
    @(posedge clk);
    swr <= 1'b0;
    wstart <= 1'b0;
    @(negedge clk);
  endtask

  // Load the shift register
  task automatic dw(input logic [7:0] d);
    @(posedge clk);
    dwr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    dwr <= 1'b0;
    @(negedge clk);
  endtask

  // Take one received byte, bounded wait
  task automatic drain(input logic [7:0] exp, input bit chk);
    int i;
    i = 0;
    while (rx_valid !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (i >= 100) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (chk) `CHK(rx_data, exp)
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    // Leave the launching edge behind before anyone looks again
    @(negedge clk);
  endtask

  // Slave byte exchange, clock mode 0 then mode 1
  task automatic t_ext();
    logic [7:0] rx;
    cfg('{`USSU_WM_THREE, 1'b1, 1'b0, 1'b0, 1'b0});
    dw(8'hA5);
    stw(4'h0);
    `CHK(so, 1'b1)
    spi_u.xfer(8'h3C, 1'b0, rx);
    repeat (6) @(negedge clk);
    `CHK(ovf, 1'b1)
    `CHK(cnt, 4'h0)
    `CHK(rdata, 8'h3C)
    `CHK(rx, 8'hA5)
    `CHK(wake, 1'b1)
    drain(8'h3C, 1'b1);
    cfg('{`USSU_WM_THREE, 1'b1, 1'b1, 1'b0, 1'b0});
    stw(4'h0);
    `CHK(ovf, 1'b0)
    spi_u.xfer(8'hC3, 1'b1, rx);
    repeat (6) @(negedge clk);
    `CHK(ovf, 1'b1)
    `CHK(cnt, 4'h0)
    drain(8'h00, 1'b0);
  endtask

  // Internal sources: strobe, wrap, clear, mixed, timer, collision, toggle
  task automatic t_int();
    logic b;
    cfg('{`USSU_WM_THREE, 1'b0, 1'b0, 1'b1, 1'b0});
    stw(4'h0);
    pulse(5, 1'b0);
    `CHK(cnt, 4'h5)
    stw(4'hE);
    pulse(1, 1'b0);
    `CHK(cnt, `USSU_CNT_MAX)
    `CHK(ovf, 1'b0)
    pulse(1, 1'b0);
    `CHK(cnt, 4'h0)
    `CHK(ovf, 1'b1)
    stw(4'h0);
    `CHK(ovf, 1'b0)
    drain(8'h00, 1'b0);
    cfg('{`USSU_WM_THREE, 1'b1, 1'b0, 1'b1, 1'b1});
    stw(4'h0);
    pulse(3, 1'b0);
    `CHK(cnt, 4'h3)
    cfg('{`USSU_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b0});
    stw(4'h0);
    pulse(3, 1'b1);
    `CHK(cnt, 4'h3)
    cfg('{`USSU_WM_THREE, 1'b0, 1'b0, 1'b1, 1'b0});
    @(posedge clk);
    dwr <= 1'b1;
    wdata <= 8'h5A;
    ctrl_wr <= 1'b1;
    @(posedge clk);
    dwr <= 1'b0;
    ctrl_wr <= 1'b0;
    @(negedge clk);
    `CHK(rdata, 8'h5A)
    `CHK(so, 1'b0)
    b = sck_out;
    cfg('{`USSU_WM_THREE, 1'b0, 1'b0, 1'b0, 1'b1});
    pulse(1, 1'b0);
    `CHK(sck_out, ~b)
  endtask

  // Two bytes land while the reader stalls, then drain in order
  task automatic t_buf();
    logic [7:0] rx;
    cfg('{`USSU_WM_THREE, 1'b1, 1'b0, 1'b0, 1'b0});
    for (int k = 0; k < 2; k++) begin
      dw(8'h00);
      stw(4'h0);
      spi_u.xfer(k ? 8'h22 : 8'h11, 1'b0, rx);
      repeat (6) @(negedge clk);
    end
    drain(8'h11, 1'b1);
    drain(8'h22, 1'b1);
    repeat (5) @(negedge clk);
    `CHK(rx_valid, 1'b0)
  endtask

  // Two-wire: data pin drive, start flag, clock held low until cleared
  task automatic t_two();
    cfg('{`USSU_WM_TWO, 1'b0, 1'b0, 1'b0, 1'b0});
    dw(8'h80);
    `CHK(sda_oe, 1'b0)
    `CHK(so, 1'b0)
    dw(8'h00);
    `CHK(sda_oe, 1'b1)
    `CHK(sda_out, 1'b0)
    stw(4'h0, 1'b1);
    spi_u.start_cond();
    repeat (4) @(negedge clk);
    `CHK(sflag, 1'b1)
    `CHK(sck_oe, 1'b1)
    `CHK(sck_out, 1'b0)
    `CHK(wake, 1'b1)
    stw(4'h0, 1'b1);
    `CHK(sflag, 1'b0)
    `CHK(sck_oe, 1'b0)
  endtask

  // Hang guard
  initial begin
    #4000000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    compares = 0;
    resetn = 1'b0;
    ctrl = '0;
    {ctrl_wr, tmr, dwr, swr, rx_ready, wstart} = '0;
    wdata = 8'h00;
    wcnt = 4'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK(cnt, 4'h0)
    `CHK(rdata, 8'h00)
    t_ext();
    t_int();
    t_buf();
    t_two();
    tally_and_finish();
  end
endmodule
